// file: hw/ises_top.sv
// status event register bank: four event sets with query port
`timescale 1ns/1ps
module ises_top
  import ises_pkg::*;
(
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // command port
  input wire logic i_cmd_valid,
  input wire ises_cmd_t i_cmd,
  input wire logic [REG_W-1:0] i_cmd_data,
  output logic o_cmd_ready,
  output logic o_rsp_valid,
  output logic [REG_W-1:0] o_rsp_data,
  // standard event sources
  input wire logic i_ops_pending,
  input wire logic i_oq_empty_read,
  input wire logic i_err_scan_resume,
  input wire logic i_err_data_lost,
  input wire logic i_exec_error,
  input wire logic i_err_setup_mismatch,
  input wire logic i_err_card_comm,
  input wire logic i_err_card_unsupported,
  input wire logic i_local_key,
  // operation conditions
  input wire logic i_measuring,
  input wire logic i_waiting_trigger,
  input wire logic i_filter_settled,
  input wire logic i_filter_disabled,
  input wire logic i_idle,
  // reading results
  input wire logic i_reading_done,
  input wire logic i_reading_overflow,
  input wire logic i_low_limit_one,
  input wire logic i_high_limit_one,
  input wire logic i_low_limit_two,
  input wire logic i_high_limit_two,
  input wire logic i_hardware_limit,
  // reading buffer state
  input wire logic [REG_W-1:0] i_buf_count,
  input wire logic [REG_W-1:0] i_buf_size,
  input wire logic i_buf_wrap,
  // questionable sources
  input wire logic i_tc_ref_invalid,
  input wire logic i_cal_bad_at_power_up,
  input wire logic i_cal_success,
  input wire logic i_cmd_param_ignored,
  // summaries and indicator
  output logic o_std_summary,
  output logic o_oper_summary,
  output logic o_meas_summary,
  output logic o_ques_summary,
  output logic o_err_indicator
);

  typedef enum logic {
    ISES_CMPL_IDLE,
    ISES_CMPL_WAIT
  } ises_cmpl_state_t;

  // rising edge of every bit of a condition word
  function automatic logic [REG_W-1:0] rise(
    input logic [REG_W-1:0] cur,
    input logic [REG_W-1:0] prev
  );
    rise = cur & ~prev;
  endfunction

  ises_cmpl_state_t cmpl_q;
  logic cmd_take;
  logic cmpl_done;
  logic local_key_lvl;
  logic local_key_q;
  logic pwr_pending_q;
  logic [STD_W-1:0] std_en_q;
  logic [REG_W-1:0] oper_en_q;
  logic [REG_W-1:0] meas_en_q;
  logic [REG_W-1:0] ques_en_q;
  logic [REG_W-1:0] notify_q;
  logic cal_invalid_q;
  logic rdy_cond_q;
  logic [REG_W-1:0] last_limits_q;
  logic [REG_W-1:0] oper_cond;
  logic [REG_W-1:0] meas_cond;
  logic [REG_W-1:0] ques_cond;
  logic [REG_W-1:0] oper_prev_q;
  logic [REG_W-1:0] meas_prev_q;
  logic [REG_W-1:0] ques_prev_q;
  logic [STD_W-1:0] std_set;
  logic [REG_W-1:0] meas_pulse;
  logic [REG_W-1:0] ques_pulse;
  logic [REG_W-1:0] reading_flags;
  logic [REG_W-1:0] buf_quarter;
  logic [REG_W-1:0] buf_half;
  logic [REG_W-1:0] buf_three_q;
  logic buf_small;
  logic any_limit;
  logic [STD_W-1:0] std_event;
  logic [REG_W-1:0] oper_event;
  logic [REG_W-1:0] meas_event;
  logic [REG_W-1:0] ques_event;
  logic std_sum;
  logic oper_sum;
  logic meas_sum;
  logic ques_sum;
  logic clr_status;
  logic rsp_valid_q;
  logic [REG_W-1:0] rsp_data_q;
  logic std_sum_q;
  logic oper_sum_q;
  logic meas_sum_q;
  logic ques_sum_q;
  logic err_ind_q;

  assign o_cmd_ready = (cmpl_q == ISES_CMPL_IDLE);
  assign cmd_take = i_cmd_valid && o_cmd_ready;
  assign clr_status = cmd_take && (i_cmd == ISES_CLEAR_STATUS);

  // front-panel key arrives from a pin
  ises_sync u_key_sync (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_pin(i_local_key),
    .o_level(local_key_lvl)
  );

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      local_key_q <= 1'b0;
    end else begin
      local_key_q <= local_key_lvl;
    end
  end

  // one power-on event after each reset release
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pwr_pending_q <= 1'b1;
    end else begin
      pwr_pending_q <= 1'b0;
    end
  end

  // completion query waits for pending operations
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cmpl_q <= ISES_CMPL_IDLE;
    end else begin
      unique case (cmpl_q)
        ISES_CMPL_IDLE: begin
          if (cmd_take && i_cmd == ISES_DONE_QUERY) begin
            cmpl_q <= ISES_CMPL_WAIT;
          end
        end
        ISES_CMPL_WAIT: begin
          if (!i_ops_pending) begin
            cmpl_q <= ISES_CMPL_IDLE;
          end
        end
      endcase
    end
  end

  assign cmpl_done = (cmpl_q == ISES_CMPL_WAIT) && !i_ops_pending;

  // standard event sources
  always_comb begin
    std_set = STD_ZERO;
    std_set[STD_DONE_BIT] = cmpl_done;
    std_set[STD_QERR_BIT] = i_oq_empty_read;
    std_set[STD_BME_BIT] = i_err_scan_resume | i_err_data_lost;
    std_set[STD_XERR_BIT] = i_exec_error;
    std_set[STD_DERR_BIT] = i_err_setup_mismatch | i_err_card_comm
                            | i_err_card_unsupported;
    std_set[STD_UREQ_BIT] = local_key_lvl & ~local_key_q;
    std_set[STD_PWR_BIT] = pwr_pending_q;
  end

  // enable registers and notify count
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      std_en_q <= STD_ZERO;
      oper_en_q <= REG_ZERO;
      meas_en_q <= REG_ZERO;
      ques_en_q <= REG_ZERO;
    end else if (cmd_take) begin
      unique case (i_cmd)
        ISES_WR_STD_EN: std_en_q <= i_cmd_data[STD_W-1:0];
        ISES_WR_OPER_EN: oper_en_q <= i_cmd_data;
        ISES_WR_MEAS_EN: meas_en_q <= i_cmd_data;
        ISES_WR_QUES_EN: ques_en_q <= i_cmd_data;
        ISES_STATUS_PRESET: begin
          oper_en_q <= REG_ZERO;
          meas_en_q <= REG_ZERO;
          ques_en_q <= REG_ZERO;
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      notify_q <= REG_ZERO;
    end else if (cmd_take && i_cmd == ISES_WR_NOTIFY) begin
      notify_q <= i_cmd_data;
    end
  end

  // operation condition word
  always_comb begin
    oper_cond = REG_ZERO;
    oper_cond[OPER_MEAS_BIT] = i_measuring;
    oper_cond[OPER_TRIG_BIT] = i_waiting_trigger;
    oper_cond[OPER_FILT_BIT] = i_filter_settled | i_filter_disabled;
    oper_cond[OPER_IDLE_BIT] = i_idle;
  end

  // per-reading flags, kept as the last reading's state
  always_comb begin
    reading_flags = REG_ZERO;
    reading_flags[MEAS_OVR_BIT] = i_reading_overflow;
    reading_flags[MEAS_LO1_BIT] = i_low_limit_one;
    reading_flags[MEAS_HI1_BIT] = i_high_limit_one;
    reading_flags[MEAS_LO2_BIT] = i_low_limit_two;
    reading_flags[MEAS_HI2_BIT] = i_high_limit_two;
    reading_flags[MEAS_HWL_BIT] = i_hardware_limit;
    reading_flags[MEAS_MLIM_BIT] = any_limit;
  end

  assign any_limit = i_low_limit_one | i_high_limit_one | i_low_limit_two
                     | i_high_limit_two | i_hardware_limit;

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      last_limits_q <= REG_ZERO;
      rdy_cond_q <= 1'b0;
    end else begin
      rdy_cond_q <= i_reading_done;
      if (i_reading_done) begin
        last_limits_q <= reading_flags;
      end
    end
  end

  // buffer fill thresholds
  assign buf_quarter = i_buf_size >> 2;
  assign buf_half = i_buf_size >> 1;
  assign buf_three_q = i_buf_size - buf_quarter;
  assign buf_small = i_buf_size < BUF_QUARTER_MIN;

  always_comb begin
    meas_cond = last_limits_q;
    meas_cond[MEAS_RDY_BIT] = rdy_cond_q;
    meas_cond[MEAS_NTF_BIT] = (notify_q != REG_ZERO)
                              && (i_buf_count >= notify_q);
    meas_cond[MEAS_AVL_BIT] = i_buf_count >= BUF_AVAIL_MIN;
    meas_cond[MEAS_QTR_BIT] = !buf_small
                              && (i_buf_count >= buf_quarter);
    meas_cond[MEAS_HALF_BIT] = (i_buf_size != REG_ZERO)
                               && (i_buf_count >= buf_half);
    meas_cond[MEAS_TQTR_BIT] = !buf_small
                               && (i_buf_count >= buf_three_q);
    meas_cond[MEAS_BFL_BIT] = (i_buf_size != REG_ZERO)
                              && (i_buf_count >= i_buf_size);
  end

  // each reading sets its own bits, even when repeated
  always_comb begin
    meas_pulse = i_reading_done ? reading_flags : REG_ZERO;
    meas_pulse[MEAS_RDY_BIT] = i_reading_done;
    meas_pulse[MEAS_WRAP_BIT] = i_buf_wrap;
  end

  // calibration fault holds until a good calibration
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cal_invalid_q <= 1'b0;
    end else if (i_cal_bad_at_power_up) begin
      cal_invalid_q <= 1'b1;
    end else if (i_cal_success) begin
      cal_invalid_q <= 1'b0;
    end
  end

  always_comb begin
    ques_cond = REG_ZERO;
    ques_cond[QUES_TEMP_BIT] = i_tc_ref_invalid;
    ques_cond[QUES_CAL_BIT] = cal_invalid_q;
    ques_pulse = REG_ZERO;
    ques_pulse[QUES_WARN_BIT] = i_cmd_param_ignored;
  end

  // previous conditions for edge detection
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      oper_prev_q <= REG_ZERO;
      meas_prev_q <= REG_ZERO;
      ques_prev_q <= REG_ZERO;
    end else begin
      oper_prev_q <= oper_cond;
      meas_prev_q <= meas_cond;
      ques_prev_q <= ques_cond;
    end
  end

  // the four event sets
  ises_event_set #(
    .W(STD_W)
  ) u_std (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_set(std_set),
    .i_clr(clr_status || (cmd_take && i_cmd == ISES_RD_STD_EVENT)),
    .i_enable(std_en_q),
    .o_event(std_event),
    .o_summary(std_sum)
  );

  ises_event_set #(
    .W(REG_W)
  ) u_oper (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_set(rise(oper_cond, oper_prev_q)),
    .i_clr(clr_status || (cmd_take && i_cmd == ISES_RD_OPER_EVENT)),
    .i_enable(oper_en_q),
    .o_event(oper_event),
    .o_summary(oper_sum)
  );

  ises_event_set #(
    .W(REG_W)
  ) u_meas (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_set(rise(meas_cond, meas_prev_q) | meas_pulse),
    .i_clr(clr_status || (cmd_take && i_cmd == ISES_RD_MEAS_EVENT)),
    .i_enable(meas_en_q),
    .o_event(meas_event),
    .o_summary(meas_sum)
  );

  ises_event_set #(
    .W(REG_W)
  ) u_ques (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_set(rise(ques_cond, ques_prev_q) | ques_pulse),
    .i_clr(clr_status || (cmd_take && i_cmd == ISES_RD_QUES_EVENT)),
    .i_enable(ques_en_q),
    .o_event(ques_event),
    .o_summary(ques_sum)
  );

  // read answers one cycle after the command; completion answer once operations are no longer pending
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rsp_valid_q <= 1'b0;
      rsp_data_q <= REG_ZERO;
    end else begin
      rsp_valid_q <= 1'b0;
      if (cmpl_done) begin
        rsp_valid_q <= 1'b1;
        rsp_data_q <= CMPL_DONE_WORD;
      end else if (cmd_take) begin
        rsp_valid_q <= 1'b1;
        unique case (i_cmd)
          ISES_RD_STD_EVENT: rsp_data_q <= {{(REG_W-STD_W){1'b0}}, std_event};
          ISES_RD_OPER_EVENT: rsp_data_q <= oper_event;
          ISES_RD_MEAS_EVENT: rsp_data_q <= meas_event;
          ISES_RD_QUES_EVENT: rsp_data_q <= ques_event;
          ISES_RD_OPER_COND: rsp_data_q <= oper_cond;
          ISES_RD_MEAS_COND: rsp_data_q <= meas_cond;
          ISES_RD_QUES_COND: rsp_data_q <= ques_cond;
          ISES_RD_STD_EN: rsp_data_q <= {{(REG_W-STD_W){1'b0}}, std_en_q};
          ISES_RD_OPER_EN: rsp_data_q <= oper_en_q;
          ISES_RD_MEAS_EN: rsp_data_q <= meas_en_q;
          ISES_RD_QUES_EN: rsp_data_q <= ques_en_q;
          ISES_RD_NOTIFY: rsp_data_q <= notify_q;
          default: rsp_valid_q <= 1'b0;
        endcase
      end
    end
  end

  // registered summaries and indicator
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      std_sum_q <= 1'b0;
      oper_sum_q <= 1'b0;
      meas_sum_q <= 1'b0;
      ques_sum_q <= 1'b0;
      err_ind_q <= 1'b0;
    end else begin
      std_sum_q <= std_sum;
      oper_sum_q <= oper_sum;
      meas_sum_q <= meas_sum;
      ques_sum_q <= ques_sum;
      err_ind_q <= (|ques_cond) | ques_event[QUES_WARN_BIT];
    end
  end

  assign o_rsp_valid = rsp_valid_q;
  assign o_rsp_data = rsp_data_q;
  assign o_std_summary = std_sum_q;
  assign o_oper_summary = oper_sum_q;
  assign o_meas_summary = meas_sum_q;
  assign o_ques_summary = ques_sum_q;
  assign o_err_indicator = err_ind_q;

endmodule

// file: include/ises_pkg.sv
// constants and types shared by the status event register bank
package ises_pkg;

  // register widths
  localparam int STD_W = 8;
  localparam int REG_W = 16;

  // standard event bit positions
  localparam int STD_DONE_BIT = 0;
  localparam int STD_QERR_BIT = 2;
  localparam int STD_BME_BIT = 3;
  localparam int STD_XERR_BIT = 4;
  localparam int STD_DERR_BIT = 5;
  localparam int STD_UREQ_BIT = 6;
  localparam int STD_PWR_BIT = 7;

  // operation bit positions
  localparam int OPER_MEAS_BIT = 4;
  localparam int OPER_TRIG_BIT = 5;
  localparam int OPER_FILT_BIT = 8;
  localparam int OPER_IDLE_BIT = 10;

  // measurement bit positions
  localparam int MEAS_OVR_BIT = 0;
  localparam int MEAS_LO1_BIT = 1;
  localparam int MEAS_HI1_BIT = 2;
  localparam int MEAS_LO2_BIT = 3;
  localparam int MEAS_HI2_BIT = 4;
  localparam int MEAS_RDY_BIT = 5;
  localparam int MEAS_NTF_BIT = 6;
  localparam int MEAS_AVL_BIT = 7;
  localparam int MEAS_HALF_BIT = 8;
  localparam int MEAS_BFL_BIT = 9;
  localparam int MEAS_WRAP_BIT = 10;
  localparam int MEAS_HWL_BIT = 11;
  localparam int MEAS_QTR_BIT = 12;
  localparam int MEAS_TQTR_BIT = 13;
  localparam int MEAS_MLIM_BIT = 14;

  // questionable bit positions
  localparam int QUES_TEMP_BIT = 4;
  localparam int QUES_CAL_BIT = 8;
  localparam int QUES_WARN_BIT = 14;

  // reset values, completion answer word and thresholds
  localparam logic [STD_W-1:0] STD_ZERO = 8'h00;
  localparam logic [REG_W-1:0] REG_ZERO = 16'h0000;
  localparam logic [REG_W-1:0] CMPL_DONE_WORD = 16'h0001;
  localparam logic [REG_W-1:0] BUF_AVAIL_MIN = 16'h0002;
  localparam logic [REG_W-1:0] BUF_QUARTER_MIN = 16'h0004;

  // status query and program commands
  typedef enum logic [4:0] {
    ISES_CMD_NONE,
    ISES_RD_STD_EVENT,
    ISES_RD_OPER_EVENT,
    ISES_RD_MEAS_EVENT,
    ISES_RD_QUES_EVENT,
    ISES_RD_OPER_COND,
    ISES_RD_MEAS_COND,
    ISES_RD_QUES_COND,
    ISES_WR_STD_EN,
    ISES_RD_STD_EN,
    ISES_WR_OPER_EN,
    ISES_RD_OPER_EN,
    ISES_WR_MEAS_EN,
    ISES_RD_MEAS_EN,
    ISES_WR_QUES_EN,
    ISES_RD_QUES_EN,
    ISES_CLEAR_STATUS,
    ISES_STATUS_PRESET,
    ISES_DONE_QUERY,
    ISES_WR_NOTIFY,
    ISES_RD_NOTIFY
  } ises_cmd_t;

endpackage

// file: hw/ises_sync.sv
// two-stage synchroniser for an asynchronous pin level
`timescale 1ns/1ps
module ises_sync (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // pin in, synchronised level out
  input wire logic i_pin,
  output logic o_level
);

  logic meta_q;
  logic level_q;

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_q <= 1'b0;
      level_q <= 1'b0;
    end else begin
      meta_q <= i_pin;
      level_q <= meta_q;
    end
  end

  assign o_level = level_q;

endmodule

// file: hw/ises_event_set.sv
// one latched event register with enable and summary
`timescale 1ns/1ps
module ises_event_set #(
  parameter int W = 16
) (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // set pulses, clear and enable
  input wire logic [W-1:0] i_set,
  input wire logic i_clr,
  input wire logic [W-1:0] i_enable,
  // latched bits and summary
  output logic [W-1:0] o_event,
  output logic o_summary
);

  logic [W-1:0] event_q;
  logic [W-1:0] event_d;

  // a set in the clearing cycle survives
  always_comb begin
    event_d = (i_clr ? '0 : event_q) | i_set;
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      event_q <= '0;
    end else begin
      event_q <= event_d;
    end
  end

  assign o_event = event_q;
  assign o_summary = |(event_q & i_enable);

endmodule

// file: testbench/ises_top_assertions.sv
// assertion checker for the status event register bank ports
`timescale 1ns/1ps
module ises_top_assertions
  import ises_pkg::*;
(
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // command port
  input wire logic i_cmd_valid,
  input wire ises_cmd_t i_cmd,
  input wire logic o_cmd_ready,
  input wire logic o_rsp_valid,
  input wire logic [REG_W-1:0] o_rsp_data,
  // condition sources and indicator
  input wire logic i_ops_pending,
  input wire logic i_measuring,
  input wire logic i_waiting_trigger,
  input wire logic i_filter_settled,
  input wire logic i_filter_disabled,
  input wire logic i_idle,
  input wire logic i_tc_ref_invalid,
  input wire logic i_cmd_param_ignored,
  input wire logic o_err_indicator
);
  logic take;
  logic [REG_W-1:0] oper_cond;
  assign take = i_cmd_valid && o_cmd_ready;
  assign oper_cond = {5'h00, i_idle, 1'b0,
    i_filter_settled | i_filter_disabled, 2'h0, i_waiting_trigger,
    i_measuring, 4'h0};
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_rst_n);

  property p_read_answer;
    take && i_cmd inside {ISES_RD_STD_EVENT, ISES_RD_OPER_EVENT,
      ISES_RD_MEAS_EVENT, ISES_RD_QUES_EVENT, ISES_RD_OPER_COND,
      ISES_RD_MEAS_COND, ISES_RD_QUES_COND} |=> o_rsp_valid;
  endproperty
  a_read_answer: assert property (p_read_answer)
    else $error("read command not answered next cycle");

  property p_no_answer;
    take && i_cmd inside {ISES_CMD_NONE, ISES_WR_STD_EN, ISES_WR_OPER_EN,
      ISES_WR_MEAS_EN, ISES_WR_QUES_EN, ISES_CLEAR_STATUS,
      ISES_STATUS_PRESET, ISES_WR_NOTIFY} |=> !o_rsp_valid;
  endproperty
  a_no_answer: assert property (p_no_answer)
    else $error("write command produced an answer");

  property p_done_wait;
    take && i_cmd == ISES_DONE_QUERY |=> !o_cmd_ready;
  endproperty
  a_done_wait: assert property (p_done_wait)
    else $error("completion query did not hold off commands");

  property p_done_hold;
    !o_cmd_ready && i_ops_pending |=> !o_cmd_ready && !o_rsp_valid;
  endproperty
  a_done_hold: assert property (p_done_hold)
    else $error("completion answered while operations pending");

  property p_done_answer;
    !o_cmd_ready && !i_ops_pending |=>
      o_rsp_valid && o_rsp_data == CMPL_DONE_WORD && o_cmd_ready;
  endproperty
  a_done_answer: assert property (p_done_answer)
    else $error("completion answer missing or wrong");

  property p_std_upper;
    take && i_cmd inside {ISES_RD_STD_EVENT, ISES_RD_STD_EN} |=>
      o_rsp_data[15:8] == 8'h00;
  endproperty
  a_std_upper: assert property (p_std_upper)
    else $error("standard register answer has upper bits set");

  property p_oper_cond;
    take && i_cmd == ISES_RD_OPER_COND |=> o_rsp_data == $past(oper_cond);
  endproperty
  a_oper_cond: assert property (p_oper_cond)
    else $error("operation condition answer wrong");

  property p_err_tc;
    i_tc_ref_invalid |=> o_err_indicator;
  endproperty
  a_err_tc: assert property (p_err_tc)
    else $error("indicator off with junction fault present");

  property p_err_warn;
    i_cmd_param_ignored |-> ##2 o_err_indicator;
  endproperty
  a_err_warn: assert property (p_err_warn)
    else $error("indicator off after ignored parameter");

  property p_rsp_hold;
    !o_rsp_valid |-> $stable(o_rsp_data);
  endproperty
  a_rsp_hold: assert property (p_rsp_hold)
    else $error("answer data changed without an answer");
endmodule

bind ises_top ises_top_assertions ises_top_assertions_i (
  .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_cmd_valid(i_cmd_valid),
  .i_cmd(i_cmd), .o_cmd_ready(o_cmd_ready), .o_rsp_valid(o_rsp_valid),
  .o_rsp_data(o_rsp_data), .i_ops_pending(i_ops_pending),
  .i_measuring(i_measuring), .i_waiting_trigger(i_waiting_trigger),
  .i_filter_settled(i_filter_settled),
  .i_filter_disabled(i_filter_disabled), .i_idle(i_idle),
  .i_tc_ref_invalid(i_tc_ref_invalid),
  .i_cmd_param_ignored(i_cmd_param_ignored),
  .o_err_indicator(o_err_indicator)
);

// file: testbench/ises_ctrl_model.sv
// controller model issuing status commands on the query port
`timescale 1ns/1ps
module ises_ctrl_model
  import ises_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_cmd_ready,
  input wire logic i_rsp_valid,
  input wire logic [REG_W-1:0] i_rsp_data,
  output logic o_cmd_valid,
  output ises_cmd_t o_cmd,
  output logic [REG_W-1:0] o_cmd_data
);
  initial begin
    o_cmd_valid = 1'b0;
    o_cmd = ISES_CMD_NONE;
    o_cmd_data = REG_ZERO;
  end
  // request held until taken; data line inverted once released
  task automatic xfer(input ises_cmd_t c, input logic [REG_W-1:0] d,
                      input bit ans, output logic [REG_W-1:0] r,
                      output bit ok);
    int n;
    bit rdy;
    ok = 1'b0;
    r = REG_ZERO;
    @(posedge i_sys_clk);
    #1;
    o_cmd_valid = 1'b1;
    o_cmd = c;
    o_cmd_data = d;
    for (n = 0; n < 50 && !i_cmd_ready; n++) begin
      @(posedge i_sys_clk);
      #1;
    end
    rdy = i_cmd_ready;
    @(posedge i_sys_clk);
    #1;
    o_cmd_valid = 1'b0;
    o_cmd_data = ~d;
    ok = !ans && rdy;
    for (n = 0; n < 200 && ans && rdy && !ok; n++) begin
      if (i_rsp_valid) begin
        r = i_rsp_data;
        ok = 1'b1;
      end else begin
        @(posedge i_sys_clk);
        #1;
      end
    end
  endtask
endmodule

// file: testbench/ises_top_tb.sv
// self-checking testbench for the status event register bank
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
  mismatches++; $display("ERROR %s exp %h got %h", nm, e, g); end end
module ises_top_tb
  import ises_pkg::*;
;
  logic sys_clk, rst_n, ops_pending, local_key, done, buf_wrap;
  logic measuring, waiting_trigger, filt_set, filt_dis, idle;
  logic tc_bad, cal_bad, cal_ok, ignored, cmd_valid, cmd_ready, rsp_valid;
  logic std_sum, oper_sum, meas_sum, ques_sum, err_ind;
  logic [6:0] se;
  logic [5:0] mf;
  logic [REG_W-1:0] bcnt, bsize, r, cmd_data, rsp_data;
  ises_cmd_t cmd;
  int mismatches, n_compared, k;
  int sb[7] = '{2, 3, 3, 4, 5, 5, 5};
  int mb[6] = '{0, 1, 2, 3, 4, 11};
  int cnts[5] = '{2, 4, 8, 12, 16};
  logic [REG_W-1:0] bexp[5] = '{16'h0080, 16'h1000, 16'h0100, 16'h2040,
    16'h0200};

  ises_top ises_top_i (
    .i_sys_clk(sys_clk), .i_rst_n(rst_n), .i_cmd_valid(cmd_valid),
    .i_cmd(cmd), .i_cmd_data(cmd_data), .o_cmd_ready(cmd_ready),
    .o_rsp_valid(rsp_valid), .o_rsp_data(rsp_data),
    .i_ops_pending(ops_pending), .i_oq_empty_read(se[0]),
    .i_err_scan_resume(se[1]), .i_err_data_lost(se[2]),
    .i_exec_error(se[3]), .i_err_setup_mismatch(se[4]),
    .i_err_card_comm(se[5]), .i_err_card_unsupported(se[6]),
    .i_local_key(local_key), .i_measuring(measuring),
    .i_waiting_trigger(waiting_trigger), .i_filter_settled(filt_set),
    .i_filter_disabled(filt_dis), .i_idle(idle), .i_reading_done(done),
    .i_reading_overflow(mf[0]), .i_low_limit_one(mf[1]),
    .i_high_limit_one(mf[2]), .i_low_limit_two(mf[3]),
    .i_high_limit_two(mf[4]), .i_hardware_limit(mf[5]),
    .i_buf_count(bcnt), .i_buf_size(bsize), .i_buf_wrap(buf_wrap),
    .i_tc_ref_invalid(tc_bad), .i_cal_bad_at_power_up(cal_bad),
    .i_cal_success(cal_ok), .i_cmd_param_ignored(ignored),
    .o_std_summary(std_sum), .o_oper_summary(oper_sum),
    .o_meas_summary(meas_sum), .o_ques_summary(ques_sum),
    .o_err_indicator(err_ind)
  );

  ises_ctrl_model ises_ctrl_model_i (
    .i_sys_clk(sys_clk), .i_cmd_ready(cmd_ready), .i_rsp_valid(rsp_valid),
    .i_rsp_data(rsp_data), .o_cmd_valid(cmd_valid), .o_cmd(cmd),
    .o_cmd_data(cmd_data)
  );

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic cyc(int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic go(ises_cmd_t c, logic [REG_W-1:0] d, bit a);
    bit ok;
    ises_ctrl_model_i.xfer(c, d, a, r, ok);
    if (!ok) begin
      mismatches++;
      $display("ERROR handshake exp 1 got 0");
      stop_test();
    end
  endtask

  task automatic rd(ises_cmd_t c, logic [REG_W-1:0] e);
    go(c, REG_ZERO, 1'b1);
    `CHK(c.name(), e, r)
  endtask

  task automatic pl(ref logic s);
    cyc(1);
    s = 1'b1;
    cyc(1);
    s = 1'b0;
  endtask

  task automatic sp(int n);
    cyc(1);
    se = 7'h01 << n;
    cyc(1);
    se = 7'h00;
  endtask

  initial begin
    {rst_n, ops_pending, local_key, done, buf_wrap, measuring} = '0;
    {waiting_trigger, filt_set, filt_dis, idle, tc_bad} = '0;
    {cal_bad, cal_ok, ignored} = '0;
    se = 7'h00;
    mf = 6'h00;
    bcnt = REG_ZERO;
    bsize = REG_ZERO;
    mismatches = 0;
    n_compared = 0;
    cyc(5);
    rst_n = 1'b1;
    rd(ISES_RD_STD_EVENT, 16'h0080);
    rd(ISES_RD_STD_EVENT, REG_ZERO);
    for (k = 0; k < 7; k++) begin
      sp(k);
      rd(ISES_RD_STD_EVENT, 16'h0001 << sb[k]);
    end
    local_key = 1'b1;
    cyc(5);
    local_key = 1'b0;
    rd(ISES_RD_STD_EVENT, 16'h0040);
    ops_pending = 1'b1;
    fork
      begin
        cyc(6);
        ops_pending = 1'b0;
      end
      go(ISES_DONE_QUERY, REG_ZERO, 1'b1);
    join
    `CHK("completion answer", CMPL_DONE_WORD, r)
    rd(ISES_RD_STD_EVENT, 16'h0001);
    filt_dis = 1'b1;
    idle = 1'b1;
    cyc(2);
    rd(ISES_RD_OPER_COND, 16'h0500);
    rd(ISES_RD_OPER_EVENT, 16'h0500);
    {idle, filt_dis, filt_set, measuring, waiting_trigger} = 5'h0F;
    cyc(2);
    rd(ISES_RD_OPER_COND, 16'h0130);
    rd(ISES_RD_OPER_EVENT, 16'h0030);
    for (k = 0; k < 6; k++) begin
      cyc(1);
      mf = 6'h01 << k;
      done = 1'b1;
      cyc(1);
      mf = 6'h00;
      done = 1'b0;
      cyc(1);
      rd(ISES_RD_MEAS_EVENT, (16'h0001 << mb[k]) | 16'h0020 |
        (k > 0 ? 16'h4000 : 16'h0000));
    end
    go(ISES_WR_NOTIFY, 16'h000C, 1'b0);
    rd(ISES_RD_NOTIFY, 16'h000C);
    bsize = 16'h0010;
    for (k = 0; k < 5; k++) begin
      bcnt = cnts[k];
      cyc(2);
      rd(ISES_RD_MEAS_EVENT, bexp[k]);
    end
    pl(buf_wrap);
    cyc(1);
    rd(ISES_RD_MEAS_EVENT, 16'h0400);
    bcnt = REG_ZERO;
    cyc(2);
    rd(ISES_RD_MEAS_EVENT, REG_ZERO);
    bsize = 16'h0003;
    bcnt = 16'h0003;
    cyc(2);
    rd(ISES_RD_MEAS_EVENT, 16'h0380);
    go(ISES_WR_QUES_EN, 16'h0010, 1'b0);
    tc_bad = 1'b1;
    cyc(3);
    `CHK("ques summary", 1'b1, ques_sum)
    `CHK("indicator on", 1'b1, err_ind)
    rd(ISES_RD_QUES_COND, 16'h0010);
    tc_bad = 1'b0;
    cyc(2);
    `CHK("indicator off", 1'b0, err_ind)
    pl(cal_bad);
    cyc(1);
    rd(ISES_RD_QUES_COND, 16'h0100);
    pl(cal_ok);
    cyc(1);
    rd(ISES_RD_QUES_COND, REG_ZERO);
    pl(ignored);
    cyc(1);
    rd(ISES_RD_QUES_EVENT, 16'h4110);
    go(ISES_WR_STD_EN, 16'h0044, 1'b0);
    go(ISES_WR_MEAS_EN, 16'hFFFF, 1'b0);
    go(ISES_WR_OPER_EN, 16'h0400, 1'b0);
    rd(ISES_RD_MEAS_EN, 16'hFFFF);
    pl(buf_wrap);
    idle = 1'b1;
    sp(3);
    cyc(1);
    `CHK("meas summary", 1'b1, meas_sum)
    `CHK("oper summary", 1'b1, oper_sum)
    `CHK("std summary masked", 1'b0, std_sum)
    go(ISES_STATUS_PRESET, REG_ZERO, 1'b0);
    cyc(1);
    `CHK("meas summary off", 1'b0, meas_sum)
    rd(ISES_RD_MEAS_EN, REG_ZERO);
    rd(ISES_RD_STD_EN, 16'h0044);
    rd(ISES_RD_STD_EVENT, 16'h0010);
    sp(0);
    cyc(1);
    `CHK("std summary", 1'b1, std_sum)
    go(ISES_CLEAR_STATUS, REG_ZERO, 1'b0);
    cyc(1);
    `CHK("std summary cleared", 1'b0, std_sum)
    rd(ISES_RD_STD_EVENT, REG_ZERO);
    rd(ISES_RD_STD_EN, 16'h0044);
    stop_test();
  end
endmodule
